/* File: hrap_pkg.sv */
/*
  Constants, encodings and state type for the host register access port.
  Assumes it is compiled before the access port module that uses it.
*/
`default_nettype none

package hrap_pkg;

  // external 3-bit address map of the microport
  localparam logic [2:0] EXT_DATA_LOW = 3'h0;
  localparam logic [2:0] EXT_DATA_MID = 3'h1;
  localparam logic [2:0] EXT_DATA_HIGH = 3'h2;
  localparam logic [2:0] EXT_ADDR_PTR = 3'h6;
  localparam logic [2:0] EXT_ADDR_CTRL = 3'h7;

  // internal word and address widths
  localparam int DATA_W = 20;
  localparam int INT_ADDR_W = 10;
  localparam int HIGH_W = 4;

  // address_control_reg fields
  localparam int ACR_AUTOINC_BIT = 7;
  localparam int ACR_BCAST_BIT = 6;
  localparam logic [7:0] ACR_LOCAL_MASK = 8'h83;

  // reset values
  localparam logic [7:0] ACR_RESET = 8'h00;
  localparam logic [7:0] CAR_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [3:0] NIBBLE_RESET = 4'h0;
  localparam logic [14:0] PIN_RESET = 15'h3800;

  // host strobe modes
  localparam logic MODE_INTEL = 1'b0;
  localparam logic MODE_MOTOROLA = 1'b1;

  // serial control inputs
  localparam int SER_PORTS = 4;
  localparam int SER_SKIP = 4;
  localparam int SER_SHIFT_W = 11;
  localparam logic [4:0] SER_CNT_IDLE = 5'h00;
  localparam logic [4:0] SER_CNT_FIRST_SHIFT = 5'h05;
  localparam logic [4:0] SER_CNT_LAST = 5'h0f;

  // access source codes: 0..3 serial inputs, 4 microport
  localparam logic [2:0] SRC_MICRO = 3'h4;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT_STROBE = 2'b01,
    ST_EXEC = 2'b10
  } port_state_t;

endpackage : hrap_pkg

`default_nettype wire

/* File: host_register_access_port.sv */
/*
  Host register access port: parallel microport (intel or motorola strobes) and four
  self-framing serial control inputs feeding one arbitration point that reaches the
  internal 20-bit registers through staging bytes and an address pointer.
  Assumes the internal register space answers int_wr_o/int_rd_o with int_ack_i, and
  that the host holds address and data stable while its strobe is asserted.
*/
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - external addresses 2, 1, 0 select high nibble, mid byte, low byte staging.
// - internal words are at most twenty bits, built from the three staging registers.
// - writing the low byte moves staged data to the ten-bit internal address.
// - reading the low byte starts the internal read; mid and high follow.
// - high staging register keeps four bits; upper bits ignored, read as zero.
// - repeated strobed accesses are accepted while chip select stays low.
// - mode input low selects intel strobes, high selects motorola strobes.
// - access type decoded from select and the two strobes per mode.
// - intel mode: ready goes low at access start, released when cycle completes.
// - motorola mode: acknowledge low on completion, high after data strobe release.
// - serial input zero reaches all channels; inputs one to three only their own.
// - serial input zero wins arbitration over other serial inputs and the microport.
// - all serial control inputs run on one shared serial clock.
// - serial input frames itself from a high marker bit; frame sync unused.
// - after the marker, four bit times are skipped, then eleven bits shifted.
// - a finished serial word hands a 3-bit address and data byte onward.
// - serial word order: marker, address msb first, then data msb first.
// - autoincrement bit set bumps the pointer after every low byte access.
module host_register_access_port (
  // system clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // serial control link
  input wire logic serial_clk_i,
  input wire logic [3:0] serial_data_in_i,
  // microport pins
  input wire logic mode_i,
  input wire logic chip_select_n_i,
  input wire logic read_strobe_n_i,  // data_strobe_n in motorola mode
  input wire logic write_strobe_n_i, // read_not_write in motorola mode
  input wire logic [2:0] ext_addr_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  output logic ready_out_o,
  output logic transfer_ack_n_o,
  // internal register access
  output logic [9:0] int_addr_o,
  output logic [19:0] int_wdata_o,
  output logic [7:0] int_ctrl_o,
  output logic int_wr_o,
  output logic int_rd_o,
  input wire logic [19:0] int_rdata_i,
  input wire logic int_ack_i
);

  // strobe decode per mode
  function automatic logic strobe_on(input logic mode, input logic rd_n, input logic wr_n);
    strobe_on = (mode == hrap_pkg::MODE_MOTOROLA) ? !rd_n : (!rd_n || !wr_n);
  endfunction : strobe_on

  function automatic logic is_read(input logic mode, input logic rd_n, input logic wr_n);
    is_read = (mode == hrap_pkg::MODE_MOTOROLA) ? wr_n : !rd_n;
  endfunction : is_read

  // synchronised pins and their decode
  logic [14:0] pin_meta, pin_sync;
  logic mode_s, cs_n_s, rd_n_s, wr_n_s, access_now, read_now;
  logic [2:0] addr_s;
  logic [7:0] data_s;
  // arbitration, sequencing and handshake state
  hrap_pkg::port_state_t state, next_state;
  logic launch, l_read, micro_start, micro_done, micro_complete;
  logic exec_done, busy, ack_lo, cur_read;
  logic [2:0] l_src, l_addr, cur_src, cap_addr;
  logic [7:0] l_data, cap_data;
  logic [3:0] grant, pend, ser_evt;
  logic [1:0] sel_port;
  // host-visible registers and serial words waiting for arbitration
  logic [7:0] address_control_reg, internal_address_pointer, stage_low, stage_mid;
  logic [3:0] stage_high;
  logic [10:0] ser_cap [hrap_pkg::SER_PORTS];

  // pins come from the host's clock world: two flops before any decode
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta <= hrap_pkg::PIN_RESET;
      pin_sync <= hrap_pkg::PIN_RESET;
    end else begin
      pin_meta <= {mode_i, chip_select_n_i, read_strobe_n_i, write_strobe_n_i, ext_addr_i, data_i};
      pin_sync <= pin_meta;
    end
  end

  // split the synchronised pin word
  assign {mode_s, cs_n_s, rd_n_s, wr_n_s, addr_s, data_s} = pin_sync;

  // access decode from select and strobes
  assign access_now = !cs_n_s && strobe_on(mode_s, rd_n_s, wr_n_s);
  assign read_now = is_read(mode_s, rd_n_s, wr_n_s);

  // serial control inputs share one serial clock; each frames itself from its marker bit
  for (genvar gi = 0; gi < hrap_pkg::SER_PORTS; gi++) begin : g_ser
    logic [4:0] cnt;
    logic [9:0] shreg;
    logic [10:0] word;
    logic tgl;
    logic [2:0] tsync;

    // link side: marker, skipped bits, then address and data msb first
    always_ff @(negedge serial_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        cnt <= hrap_pkg::SER_CNT_IDLE;
        shreg <= 10'h000;
        word <= 11'h000;
        tgl <= 1'b0;
      end else if (cnt == hrap_pkg::SER_CNT_IDLE) begin
        if (serial_data_in_i[gi]) begin
          cnt <= 5'h01;
        end
      end else if (cnt < hrap_pkg::SER_CNT_FIRST_SHIFT) begin
        cnt <= cnt + 5'h01;
      end else if (cnt == hrap_pkg::SER_CNT_LAST) begin
        word <= {shreg, serial_data_in_i[gi]};
        tgl <= !tgl;
        cnt <= hrap_pkg::SER_CNT_IDLE;
      end else begin
        shreg <= {shreg[8:0], serial_data_in_i[gi]};
        cnt <= cnt + 5'h01;
      end
    end

    // toggle crossing; word stays put until the next frame ends, so it is safe to copy
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        tsync <= 3'h0;
        ser_cap[gi] <= 11'h000;
      end else begin
        tsync <= {tsync[1:0], tgl};
        if (tsync[2] != tsync[1]) begin
          ser_cap[gi] <= word;
        end
      end
    end

    assign ser_evt[gi] = tsync[2] != tsync[1];

    AST_SER_SKIP: assert property (@(negedge serial_clk_i) disable iff (!rst_n_i)
      (cnt == hrap_pkg::SER_CNT_IDLE && serial_data_in_i[gi])
        |-> ##5 (cnt == hrap_pkg::SER_CNT_FIRST_SHIFT))
      else $error("serial input did not skip four bits after the marker");
  end

  // pending serial words; a new word wins over its own grant
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend <= 4'h0;
    end else begin
      pend <= (pend & ~grant) | ser_evt;
    end
  end

  // lowest-numbered pending serial input among one to three
  always_comb begin
    sel_port = 2'h3;
    for (int i = hrap_pkg::SER_PORTS - 1; i >= 1; i--) begin
      if (pend[i]) begin
        sel_port = 2'(i);
      end
    end
  end

  // arbitration and sequencing of byte operations
  always_comb begin
    next_state = state;
    launch = 1'b0;
    l_src = hrap_pkg::SRC_MICRO;
    l_read = 1'b0;
    l_addr = cap_addr;
    l_data = cap_data;
    grant = 4'h0;
    micro_start = 1'b0;
    case (state)
      hrap_pkg::ST_IDLE: begin
        if (pend[0]) begin
          launch = 1'b1;
          l_src = 3'h0;
          l_addr = ser_cap[0][10:8];
          l_data = ser_cap[0][7:0];
          grant[0] = 1'b1;
        end else if (access_now && !micro_done) begin
          micro_start = 1'b1;
          if (mode_s == hrap_pkg::MODE_INTEL && !read_now) begin
            next_state = hrap_pkg::ST_WAIT_STROBE;
          end else begin
            launch = 1'b1;
            l_read = read_now;
            l_addr = addr_s;
            l_data = data_s;
          end
        end else if (pend[3:1] != 3'h0) begin
          launch = 1'b1;
          l_src = {1'b0, sel_port};
          l_addr = ser_cap[sel_port][10:8];
          l_data = ser_cap[sel_port][7:0];
          grant[sel_port] = 1'b1;
        end
      end
      hrap_pkg::ST_WAIT_STROBE: begin
        if (!access_now) begin
          launch = 1'b1;
        end
      end
      hrap_pkg::ST_EXEC: begin
        if (int_ack_i) begin
          next_state = hrap_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = hrap_pkg::ST_IDLE;
      end
    endcase
    if (launch) begin
      next_state = (l_addr == hrap_pkg::EXT_DATA_LOW) ? hrap_pkg::ST_EXEC : hrap_pkg::ST_IDLE;
    end
  end

  assign exec_done = state == hrap_pkg::ST_EXEC && int_ack_i;
  assign micro_complete = (launch && l_src == hrap_pkg::SRC_MICRO
                           && l_addr != hrap_pkg::EXT_DATA_LOW)
                          || (exec_done && cur_src == hrap_pkg::SRC_MICRO);

  // state, current operation and captured intel write
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= hrap_pkg::ST_IDLE;
      cur_src <= hrap_pkg::SRC_MICRO;
      cur_read <= 1'b0;
      cap_addr <= 3'h0;
      cap_data <= hrap_pkg::BYTE_RESET;
    end else begin
      state <= next_state;
      if (launch) begin
        cur_src <= l_src;
        cur_read <= l_read;
      end
      // keep the last sample taken while the write strobe is still low
      if (micro_start || (state == hrap_pkg::ST_WAIT_STROBE && access_now)) begin
        cap_addr <= addr_s;
        cap_data <= data_s;
      end
    end
  end

  // microport handshake: one service per strobe, ready and acknowledge per mode
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      micro_done <= 1'b0;
      busy <= 1'b0;
      ack_lo <= 1'b0;
    end else begin
      micro_done <= access_now && (micro_done || micro_start);
      busy <= (busy || micro_start) && !micro_complete;
      ack_lo <= (ack_lo && access_now)
                || (micro_complete && mode_s == hrap_pkg::MODE_MOTOROLA);
    end
  end

  // ready also falls while an access waits behind a serial operation
  assign ready_out_o = !(mode_s == hrap_pkg::MODE_INTEL
                         && (busy || (access_now && !micro_done)));
  assign transfer_ack_n_o = !ack_lo;

  // address control and pointer registers
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      address_control_reg <= hrap_pkg::ACR_RESET;
      internal_address_pointer <= hrap_pkg::CAR_RESET;
    end else if (launch && !l_read && l_addr == hrap_pkg::EXT_ADDR_CTRL) begin
      address_control_reg <= l_data;
    end else if (launch && !l_read && l_addr == hrap_pkg::EXT_ADDR_PTR) begin
      internal_address_pointer <= l_data;
    end else if (exec_done && address_control_reg[hrap_pkg::ACR_AUTOINC_BIT]) begin
      internal_address_pointer <= internal_address_pointer + 8'h01;
    end
  end

  // staging registers: host writes, or the internal word after a low byte read
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage_low <= hrap_pkg::BYTE_RESET;
      stage_mid <= hrap_pkg::BYTE_RESET;
      stage_high <= hrap_pkg::NIBBLE_RESET;
    end else if (launch && !l_read) begin
      case (l_addr)
        hrap_pkg::EXT_DATA_LOW: stage_low <= l_data;
        hrap_pkg::EXT_DATA_MID: stage_mid <= l_data;
        hrap_pkg::EXT_DATA_HIGH: stage_high <= l_data[3:0];
        default: stage_low <= stage_low;
      endcase
    end else if (exec_done && cur_read) begin
      stage_low <= int_rdata_i[7:0];
      stage_mid <= int_rdata_i[15:8];
      stage_high <= int_rdata_i[19:16];
    end
  end

  // internal access request; serial inputs one to three are held to their own channel
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      int_wr_o <= 1'b0;
      int_rd_o <= 1'b0;
      int_addr_o <= 10'h000;
      int_wdata_o <= 20'h00000;
      int_ctrl_o <= hrap_pkg::ACR_RESET;
    end else begin
      int_wr_o <= 1'b0;
      int_rd_o <= 1'b0;
      if (launch && l_addr == hrap_pkg::EXT_DATA_LOW) begin
        int_wr_o <= !l_read;
        int_rd_o <= l_read;
        int_wdata_o <= {stage_high, stage_mid, l_data};
        if (l_src != 3'h0 && l_src != hrap_pkg::SRC_MICRO) begin
          int_addr_o <= {l_src[1:0], internal_address_pointer};
          int_ctrl_o <= address_control_reg & hrap_pkg::ACR_LOCAL_MASK;
        end else begin
          int_addr_o <= {address_control_reg[1:0], internal_address_pointer};
          int_ctrl_o <= address_control_reg;
        end
      end
    end
  end

  // read data to the pins; only the microport reads
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_o <= hrap_pkg::BYTE_RESET;
      data_oe_o <= 1'b0;
    end else begin
      data_oe_o <= access_now && read_now && (micro_done || micro_start);
      if (launch && l_read) begin
        case (l_addr)
          hrap_pkg::EXT_DATA_MID: data_o <= stage_mid;
          hrap_pkg::EXT_DATA_HIGH: data_o <= {4'h0, stage_high};
          hrap_pkg::EXT_ADDR_PTR: data_o <= internal_address_pointer;
          hrap_pkg::EXT_ADDR_CTRL: data_o <= address_control_reg;
          default: data_o <= hrap_pkg::BYTE_RESET;
        endcase
      end else if (exec_done && cur_read) begin
        data_o <= int_rdata_i[7:0];
      end
    end
  end

  AST_LOW_WRITE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (launch && !l_read && l_addr == hrap_pkg::EXT_DATA_LOW)
      |=> (int_wr_o && int_wdata_o[7:0] == $past(l_data)))
    else $error("low byte write did not start an internal write");
  AST_HIGH_NIBBLE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (launch && l_read && l_addr == hrap_pkg::EXT_DATA_HIGH) |=> (data_o[7:4] == 4'h0))
    else $error("high nibble read returned upper bits");
  AST_INTEL_READY: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (mode_s == hrap_pkg::MODE_INTEL && state == hrap_pkg::ST_EXEC
     && cur_src == hrap_pkg::SRC_MICRO) |-> !ready_out_o)
    else $error("ready released before the internal cycle completed");

  AST_MOTO_ACK: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (mode_s == hrap_pkg::MODE_MOTOROLA && !transfer_ack_n_o && !access_now)
      |=> transfer_ack_n_o)
    else $error("acknowledge held after data strobe release");

  AST_MODE_SPLIT: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (mode_s == hrap_pkg::MODE_INTEL) |-> transfer_ack_n_o)
    else $error("acknowledge driven in intel mode");
  AST_SER0_FIRST: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (state == hrap_pkg::ST_IDLE && pend[0]) |-> (grant == 4'h1 && l_src == 3'h0))
    else $error("serial input zero lost arbitration");

  AST_AUTOINC: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (exec_done && address_control_reg[hrap_pkg::ACR_AUTOINC_BIT]) |=> (internal_address_pointer == $past(internal_address_pointer) + 8'h01))
    else $error("pointer not incremented after low byte access");

  AST_PORT_SCOPE: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (launch && l_addr == hrap_pkg::EXT_DATA_LOW && l_src != 3'h0
     && l_src != hrap_pkg::SRC_MICRO) |=> (int_addr_o[9:8] == $past(l_src[1:0])))
    else $error("local serial input reached another channel");

  AST_SER_HANDOFF: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    ser_evt[0] |=> (pend[0] && ser_cap[0] == $past(g_ser[0].word)))
    else $error("serial word not handed to arbitration");

endmodule : host_register_access_port

`default_nettype wire

/* File: reg_space_model.sv */
/*
  Behavioural model of the internal register space behind the host access port.
  Assumes one request pulse at a time; it answers each with a one-cycle acknowledge.
*/
`timescale 1ns/1ps
`default_nettype none

module reg_space_model (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // request side
  input wire logic [9:0] int_addr_i,
  input wire logic [19:0] int_wdata_i,
  input wire logic int_wr_i,
  input wire logic int_rd_i,
  input wire logic slow_i,
  // answer side
  output logic [19:0] int_rdata_o,
  output logic int_ack_o
);
  logic [19:0] mem [1024];
  logic [2:0] wait_cnt;
  logic busy;
  logic [9:0] addr_q;

  // slow mode stretches the answer so the port must really wait for it
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy <= 1'b0;
      wait_cnt <= 3'h0;
      int_ack_o <= 1'b0;
      int_rdata_o <= 20'h00000;
      addr_q <= 10'h000;
    end else begin
      int_ack_o <= 1'b0;
      int_rdata_o <= ~int_rdata_o; // no stale data outside acknowledge
      if (int_wr_i || int_rd_i) begin
        busy <= 1'b1;
        addr_q <= int_addr_i;
        wait_cnt <= slow_i ? 3'h4 : 3'h0;
        if (int_wr_i) begin
          mem[int_addr_i] <= int_wdata_i;
        end
      end else if (busy) begin
        if (wait_cnt == 3'h0) begin
          busy <= 1'b0;
          int_ack_o <= 1'b1;
          int_rdata_o <= mem[addr_q];
        end else begin
          wait_cnt <= wait_cnt - 3'h1;
        end
      end
    end
  end
endmodule : reg_space_model

`default_nettype wire

/* File: tb.sv */
/*
  Self-checking bench for the host register access port: microport in both strobe
  modes, serial control frames, autoincrement, unmapped addresses and a mid-run reset.
  Assumes reg_space_model answers the internal requests.
*/
`timescale 1ns/1ps
`default_nettype none

module tb;
  typedef struct packed {logic mode; logic slow; logic [9:0] addr; logic [19:0] data;} row_t;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic serial_clk_i = 1'b1;
  logic [3:0] serial_data_in_i = 4'h0;
  logic mode_i = 1'b0;
  logic chip_select_n_i = 1'b1;
  logic read_strobe_n_i = 1'b1;
  logic write_strobe_n_i = 1'b1;
  logic [2:0] ext_addr_i = 3'h0;
  logic [7:0] data_i = 8'h00;
  logic slow = 1'b0;
  logic [7:0] data_o, int_ctrl_o, q;
  logic data_oe_o, ready_out_o, transfer_ack_n_o, int_wr_o, int_rd_o, int_ack_i;
  logic [9:0] int_addr_o;
  logic [19:0] int_wdata_o, int_rdata_i;
  int n_errors = 0;
  int num_checks = 0;
  row_t rows [4] = '{'{1'b0, 1'b0, 10'h087, 20'h0cbef}, '{1'b1, 1'b1, 10'h3ff, 20'hfffff},
                     '{1'b0, 1'b1, 10'h100, 20'ha5a5a}, '{1'b1, 1'b0, 10'h000, 20'h00001}};

  // system clock, 50 MHz
  always #10 clk_sys_i = ~clk_sys_i;

  host_register_access_port DUT (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .serial_clk_i(serial_clk_i),
    .serial_data_in_i(serial_data_in_i), .mode_i(mode_i), .chip_select_n_i(chip_select_n_i),
    .read_strobe_n_i(read_strobe_n_i), .write_strobe_n_i(write_strobe_n_i),
    .ext_addr_i(ext_addr_i), .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o),
    .ready_out_o(ready_out_o), .transfer_ack_n_o(transfer_ack_n_o), .int_addr_o(int_addr_o),
    .int_wdata_o(int_wdata_o), .int_ctrl_o(int_ctrl_o), .int_wr_o(int_wr_o),
    .int_rd_o(int_rd_o), .int_rdata_i(int_rdata_i), .int_ack_i(int_ack_i));

  reg_space_model far_end (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .int_addr_i(int_addr_o),
    .int_wdata_i(int_wdata_o), .int_wr_i(int_wr_o), .int_rd_i(int_rd_o), .slow_i(slow),
    .int_rdata_o(int_rdata_i), .int_ack_o(int_ack_i));

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // bounded wait for ready (intel) or acknowledge (motorola) to reach a level
  task automatic wait_pin(input logic lvl);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys_i);
      n++;
    end while (((mode_i ? transfer_ack_n_o : ready_out_o) !== lvl) && n < 40);
    chk({19'h0, n < 40}, 20'h00001);
  endtask : wait_pin

  // one strobed microport access; select held until the answer is sampled, an intel write strobe released a clock after ready falls
  task automatic acc(input logic rd, input logic [2:0] a, input logic [7:0] d,
                     output logic [7:0] rdata);
    @(posedge clk_sys_i);
    ext_addr_i <= a;
    data_i <= d;
    chip_select_n_i <= 1'b0;
    read_strobe_n_i <= !(rd || mode_i);
    write_strobe_n_i <= rd;
    wait_pin(1'b0);
    if (!mode_i && !rd) begin
      @(posedge clk_sys_i);
      write_strobe_n_i <= 1'b1;
    end
    if (!mode_i) begin
      wait_pin(1'b1);
      @(negedge clk_sys_i);
    end
    rdata = data_o;
    if (rd) chk({19'h0, data_oe_o}, 20'h00001);
    @(posedge clk_sys_i);
    read_strobe_n_i <= 1'b1;
    write_strobe_n_i <= 1'b1;
    chip_select_n_i <= 1'b1;
    if (mode_i) wait_pin(1'b1);
    repeat (4) @(posedge clk_sys_i);
  endtask : acc

  task automatic set_addr(input logic [9:0] a);
    logic [7:0] r;
    acc(1'b0, hrap_pkg::EXT_ADDR_CTRL, {6'h00, a[9:8]}, r);
    acc(1'b0, hrap_pkg::EXT_ADDR_PTR, a[7:0], r);
  endtask : set_addr

  task automatic word_wr(input logic [9:0] a, input logic [19:0] d);
    logic [7:0] r;
    set_addr(a);
    acc(1'b0, hrap_pkg::EXT_DATA_HIGH, {4'hf, d[19:16]}, r);
    acc(1'b0, hrap_pkg::EXT_DATA_MID, d[15:8], r);
    acc(1'b0, hrap_pkg::EXT_DATA_LOW, d[7:0], r);
  endtask : word_wr

  task automatic word_rd(input logic [9:0] a, input logic [19:0] d);
    logic [7:0] r;
    set_addr(a);
    acc(1'b1, hrap_pkg::EXT_DATA_LOW, 8'h00, r);
    chk({12'h000, r}, {12'h000, d[7:0]});
    acc(1'b1, hrap_pkg::EXT_DATA_MID, 8'h00, r);
    chk({12'h000, r}, {12'h000, d[15:8]});
    acc(1'b1, hrap_pkg::EXT_DATA_HIGH, 8'h00, r);
    chk({12'h000, r}, {16'h0000, d[19:16]});
  endtask : word_rd

  // serial clock only runs inside a frame; data changes on its rising edge
  task automatic ser_frame(input int port, input logic [2:0] a, input logic [7:0] d);
    logic [15:0] bits;
    bits = {1'b1, 4'h0, a, d};
    for (int i = 15; i >= 0; i--) begin
      serial_data_in_i[port] <= bits[i];
      #7.5 serial_clk_i = 1'b0;
      #7.5 serial_clk_i = 1'b1;
    end
    serial_data_in_i[port] <= 1'b0;
    repeat (12) @(posedge clk_sys_i);
  endtask : ser_frame

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out

  // main sequence
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    foreach (rows[i]) begin
      mode_i <= rows[i].mode;
      slow <= rows[i].slow;
      repeat (4) @(posedge clk_sys_i);
      word_wr(rows[i].addr, rows[i].data);
      chk(far_end.mem[rows[i].addr], rows[i].data);
      word_rd(rows[i].addr, rows[i].data);
      $display("test row %0d done", i);
    end
    mode_i <= hrap_pkg::MODE_INTEL;
    repeat (4) @(posedge clk_sys_i);
    // unmapped addresses drop writes and read as zero
    acc(1'b0, 3'h4, 8'hff, q);
    acc(1'b1, 3'h4, 8'h00, q);
    chk({12'h000, q}, 20'h00000);
    $display("test unmapped done");
    // autoincrement across the pointer wrap
    acc(1'b0, hrap_pkg::EXT_ADDR_CTRL, 8'h81, q);
    acc(1'b0, hrap_pkg::EXT_ADDR_PTR, 8'hfe, q);
    acc(1'b0, hrap_pkg::EXT_DATA_LOW, 8'h11, q);
    acc(1'b0, hrap_pkg::EXT_DATA_LOW, 8'h22, q);
    chk({12'h000, far_end.mem[10'h1fe][7:0]}, 20'h00011);
    chk({12'h000, far_end.mem[10'h1ff][7:0]}, 20'h00022);
    chk({12'h000, int_ctrl_o}, 20'h00081);
    acc(1'b1, hrap_pkg::EXT_ADDR_PTR, 8'h00, q);
    chk({12'h000, q}, 20'h00000);
    acc(1'b0, hrap_pkg::EXT_ADDR_CTRL, 8'h00, q);
    $display("test autoincrement done");
    // serial frames: port zero is global, port two is forced to its own channel
    ser_frame(0, hrap_pkg::EXT_ADDR_PTR, 8'h33);
    acc(1'b1, hrap_pkg::EXT_ADDR_PTR, 8'h00, q);
    chk({12'h000, q}, 20'h00033);
    ser_frame(0, hrap_pkg::EXT_DATA_LOW, 8'h5c);
    chk({12'h000, far_end.mem[10'h033][7:0]}, 20'h0005c);
    ser_frame(2, hrap_pkg::EXT_DATA_LOW, 8'h9c);
    chk({12'h000, far_end.mem[10'h233][7:0]}, 20'h0009c);
    $display("test serial done");
    // second reset in mid-run, then reset values
    @(posedge clk_sys_i);
    rst_n_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    chk({16'h0000, data_oe_o, transfer_ack_n_o, ready_out_o, int_wr_o}, 20'h00006);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    acc(1'b1, hrap_pkg::EXT_ADDR_PTR, 8'h00, q);
    chk({12'h000, q}, {12'h000, hrap_pkg::CAR_RESET});
    acc(1'b1, hrap_pkg::EXT_ADDR_CTRL, 8'h00, q);
    chk({12'h000, q}, {12'h000, hrap_pkg::ACR_RESET});
    acc(1'b1, hrap_pkg::EXT_DATA_MID, 8'h00, q);
    chk({12'h000, q}, {12'h000, hrap_pkg::BYTE_RESET});
    $display("test reset done");
    close_out();
  end

  // watchdog: the tests need well under a tenth of this span
  initial begin
    #400000;
    n_errors++;
    $display("watchdog expired");
    close_out();
  end
endmodule : tb

`default_nettype wire
